// file: include/lmd_pkg.sv
/*
  Shared constants for the reference clock monitor and lock detector.
  Assumes a 100 MHz system clock derived from the oscillator input.
*/
package lmd_pkg;
  localparam int N_REF = 2;
  localparam int N_DPLL = 3;
  localparam int N_APLL = 2;
  localparam int N_PIN = 2;
  localparam int CNT_W = 24;
  localparam int AVG_W = 3;
  localparam int ACC_W = CNT_W + 8;
  localparam int SEL_W = 4;
  localparam int N_SRC = 16;

  localparam int CLK_PERIOD_NS = 10;
  // Oscillator band check: edges of the oscillator divided by a prescaler, counted over a gate
  localparam int OSC_GATE_NS = 10000;
  localparam int OSC_GATE_CYC = OSC_GATE_NS / CLK_PERIOD_NS;
  localparam int OSC_PRESCALE = 16;
  localparam int OSC_MIN_HZ = 9000000;
  localparam int OSC_MAX_HZ = 160000000;
  localparam int GATES_PER_S = 1000000000 / OSC_GATE_NS;
  localparam int OSC_MIN_CNT = (OSC_MIN_HZ / OSC_PRESCALE) / GATES_PER_S;
  localparam int OSC_MAX_CNT = (OSC_MAX_HZ / OSC_PRESCALE) / GATES_PER_S;
  localparam logic [15:0] OSC_GATE_LAST = 16'(OSC_GATE_CYC - 1);
  localparam logic [15:0] OSC_MIN = 16'(OSC_MIN_CNT);
  localparam logic [15:0] OSC_MAX = 16'(OSC_MAX_CNT);

  // Values after reset
  localparam logic RST_OSC_LOSS = 1'b1;
  localparam logic RST_REF_FLAG = 1'b0;
  localparam logic RST_LOCK_LOSS = 1'b1;
  localparam logic RST_QUAL = 1'b0;
  localparam logic [CNT_W-1:0] RST_CNT = 24'h000000;

  // Status pin source indices
  localparam int SRC_OSC = 0;
  localparam int SRC_REF_FREQ = 1;
  localparam int SRC_REF_WIN = 3;
  localparam int SRC_REF_PV = 5;
  localparam int SRC_DPLL_LOL = 7;
  localparam int SRC_APLL_LOL = 10;
endpackage : lmd_pkg

// file: hw/lmd_hyst_det.sv
/*
  Averaging threshold detector with hysteresis: accumulates 2^avg_log2 magnitude samples
  and sets or clears a flag against two thresholds. Assumes samples arrive as one-cycle strobes.
*/
`timescale 1ns/1ps
module lmd_hyst_det import lmd_pkg::*; #(
  parameter logic FLAG_RST = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic sample,
  input wire logic [CNT_W-1:0] magnitude,
  input wire logic [AVG_W-1:0] avg_log2,
  input wire logic [CNT_W-1:0] clear_thr,
  input wire logic [CNT_W-1:0] set_thr,
  output logic flag
);
  logic [ACC_W-1:0] acc, next_acc;
  logic [7:0] cnt, next_cnt;
  logic next_flag;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] mean;

  always_comb begin
    sum = acc + ACC_W'(magnitude);
    mean = sum >> avg_log2;
    next_acc = acc;
    next_cnt = cnt;
    next_flag = flag;
    if (!enable) begin
      next_acc = '0;
      next_cnt = '0;
      next_flag = 1'b0;
    end else if (sample) begin
      // Heavier averaging takes more samples per decision, and the shift keeps the mean in the units of the thresholds
      if (cnt == 8'((9'h001 << avg_log2) - 9'h001)) begin
        next_acc = '0;
        next_cnt = '0;
        if (mean < ACC_W'(clear_thr))
          next_flag = 1'b0;
        else if (mean > ACC_W'(set_thr))
          next_flag = 1'b1;
      end else begin
        next_acc = sum;
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      cnt <= 8'h00;
      flag <= FLAG_RST;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      flag <= next_flag;
    end
  end
endmodule : lmd_hyst_det

// file: hw/lmd_ref_monitor.sv
/*
  Reference clock monitor and lock detector: oscillator band check, per-reference
  frequency, window and phase-valid monitors, validation timers, PLL lock-loss flags.
  Assumes reference inputs and error strobes are synchronous to clk, and clk is
  derived from the oscillator so period counts are relative to it.
*/
`timescale 1ns/1ps
module lmd_ref_monitor import lmd_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic osc_div_tick,
  input wire logic osc_detect_bypass,
  input wire logic [N_REF-1:0] ref_in,
  input wire logic [N_REF-1:0] freq_mon_en,
  input wire logic [N_REF-1:0] late_en,
  input wire logic [N_REF-1:0] early_en,
  input wire logic [N_REF-1:0] phase_valid_en,
  input wire logic [N_REF-1:0][CNT_W-1:0] nominal_period,
  input wire logic [N_REF-1:0][CNT_W-1:0] late_threshold,
  input wire logic [N_REF-1:0][CNT_W-1:0] early_threshold,
  input wire logic [N_REF-1:0][CNT_W-1:0] jitter_window_threshold,
  input wire logic [N_REF-1:0][AVG_W-1:0] freq_avg_log2,
  input wire logic [N_REF-1:0][CNT_W-1:0] freq_valid_thr,
  input wire logic [N_REF-1:0][CNT_W-1:0] freq_invalid_thr,
  input wire logic [N_REF-1:0] valid_timer_en,
  input wire logic [N_REF-1:0][CNT_W-1:0] valid_timer,
  input wire logic [N_DPLL-1:0] dpll_sel_ref,
  input wire logic [N_DPLL-1:0] zero_delay_sync,
  input wire logic [N_DPLL-1:0] dpll_soft_reset,
  input wire logic [N_DPLL-1:0] dpll_err_strobe,
  input wire logic [N_DPLL-1:0][CNT_W-1:0] dpll_freq_err,
  input wire logic [N_DPLL-1:0][CNT_W-1:0] dpll_phase_err,
  input wire logic [N_DPLL-1:0][AVG_W-1:0] dpll_avg_log2,
  input wire logic [N_DPLL-1:0][CNT_W-1:0] dpll_freq_lock_thr,
  input wire logic [N_DPLL-1:0][CNT_W-1:0] dpll_freq_unlock_thr,
  input wire logic [N_DPLL-1:0][CNT_W-1:0] dpll_phase_lock_thr,
  input wire logic [N_DPLL-1:0][CNT_W-1:0] dpll_phase_unlock_thr,
  input wire logic [N_APLL-1:0] apll_err_strobe,
  input wire logic [N_APLL-1:0][CNT_W-1:0] apll_freq_err,
  input wire logic [N_APLL-1:0][CNT_W-1:0] apll_lock_thr,
  input wire logic [N_APLL-1:0][CNT_W-1:0] apll_unlock_thr,
  input wire logic [N_PIN-1:0][SEL_W-1:0] status_pin_sel,
  output logic osc_freq_loss_flag,
  output logic osc_valid,
  output logic [N_REF-1:0] ref_freq_error_flag,
  output logic [N_REF-1:0] ref_window_flag,
  output logic [N_REF-1:0] ref_phase_valid_flag,
  output logic [N_REF-1:0] ref_qualified,
  output logic [N_DPLL-1:0] sel_freq_error,
  output logic [N_DPLL-1:0] sel_window,
  output logic [N_DPLL-1:0] sel_phase_valid,
  output logic [N_DPLL-1:0] freq_lock_loss_flag,
  output logic [N_DPLL-1:0] phase_lock_loss_flag,
  output logic [N_DPLL-1:0] lock_loss_status,
  output logic [N_APLL-1:0] apll_lock_loss_status,
  output logic [N_DPLL-1:0] hitless_pps_ok,
  output logic [N_PIN-1:0] status_pin
);
  logic rst_sync1, rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // Oscillator band check
  logic [15:0] osc_gate, next_osc_gate;
  logic [15:0] osc_edges, next_osc_edges;
  logic next_osc_loss, next_osc_valid;

  always_comb begin
    next_osc_gate = osc_gate + 16'h0001;
    next_osc_edges = osc_edges + (osc_div_tick ? 16'h0001 : 16'h0000);
    next_osc_loss = osc_freq_loss_flag;
    if (osc_gate == OSC_GATE_LAST) begin
      next_osc_gate = 16'h0000;
      next_osc_edges = 16'h0000;
      next_osc_loss = (osc_edges < OSC_MIN) || (osc_edges > OSC_MAX);
    end
    // Bypass only affects what the PLL control sees; the flag keeps the detector result
    next_osc_valid = osc_detect_bypass | ~next_osc_loss;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_gate <= 16'h0000;
      osc_edges <= 16'h0000;
      osc_freq_loss_flag <= RST_OSC_LOSS;
      osc_valid <= 1'b0;
    end else begin
      osc_gate <= next_osc_gate;
      osc_edges <= next_osc_edges;
      osc_freq_loss_flag <= next_osc_loss;
      osc_valid <= next_osc_valid;
    end
  end

  // Per-reference monitors
  genvar r;
  generate
    for (r = 0; r < N_REF; r++) begin : g_ref
      logic ref_q, edge_seen;
      logic [CNT_W-1:0] per_cnt, next_per_cnt;
      logic [CNT_W-1:0] vt_cnt, next_vt_cnt;
      logic late_flag, next_late, early_flag, next_early, next_pv, next_qual;
      logic [CNT_W:0] period, win_late, win_early, win_pv;
      logic [CNT_W-1:0] freq_mag;
      logic any_flag;

      always_comb begin
        edge_seen = ref_in[r] & ~ref_q;
        period = {1'b0, per_cnt} + {{CNT_W{1'b0}}, 1'b1};
        win_late = {1'b0, nominal_period[r]} + {1'b0, late_threshold[r]};
        win_early = {1'b0, nominal_period[r]} - {1'b0, early_threshold[r]};
        win_pv = {1'b0, nominal_period[r]} + {1'b0, jitter_window_threshold[r]};
        freq_mag = (period > {1'b0, nominal_period[r]}) ? CNT_W'(period - {1'b0, nominal_period[r]})
                                                        : CNT_W'({1'b0, nominal_period[r]} - period);
        // Saturate so a dead input keeps its late flags set
        next_per_cnt = edge_seen ? RST_CNT : ((&per_cnt) ? per_cnt : per_cnt + 24'h000001);
        // A gap up to one period passes if the late window covers it
        next_late = late_flag;
        if (!late_en[r])
          next_late = 1'b0;
        else if (edge_seen)
          next_late = period > win_late;
        else if (period > win_late)
          next_late = 1'b1;
        next_early = early_flag;
        if (!(early_en[r] & late_en[r]))
          next_early = 1'b0;
        else if (edge_seen)
          next_early = period < win_early;
        next_pv = ref_phase_valid_flag[r];
        if (!phase_valid_en[r])
          next_pv = 1'b0;
        else if (edge_seen)
          next_pv = period > win_pv;
        else if (period > win_pv)
          next_pv = 1'b1;
        // Disabled monitors hold their flags low, so they drop out of this term
        any_flag = ref_freq_error_flag[r] | next_late | next_early | next_pv;
        next_vt_cnt = vt_cnt;
        next_qual = ref_qualified[r];
        if (any_flag) begin
          next_vt_cnt = RST_CNT;
          next_qual = 1'b0;
        end else if (!valid_timer_en[r]) begin
          next_qual = 1'b1;
        end else if (vt_cnt >= valid_timer[r]) begin
          next_qual = 1'b1;
        end else begin
          next_vt_cnt = vt_cnt + 24'h000001;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ref_q <= 1'b0;
          per_cnt <= RST_CNT;
          vt_cnt <= RST_CNT;
          late_flag <= RST_REF_FLAG;
          early_flag <= RST_REF_FLAG;
          ref_window_flag[r] <= RST_REF_FLAG;
          ref_phase_valid_flag[r] <= RST_REF_FLAG;
          ref_qualified[r] <= RST_QUAL;
        end else begin
          ref_q <= ref_in[r];
          per_cnt <= next_per_cnt;
          vt_cnt <= next_vt_cnt;
          late_flag <= next_late;
          early_flag <= next_early;
          ref_window_flag[r] <= next_late | next_early;
          ref_phase_valid_flag[r] <= next_pv;
          ref_qualified[r] <= next_qual;
        end
      end

      // Period error per edge, averaged; relies on software never enabling it with phase-valid
      lmd_hyst_det #(.FLAG_RST(RST_REF_FLAG)) u_freq (
        .clk(clk),
        .rst_n(rst_n),
        .enable(freq_mon_en[r]),
        .sample(edge_seen),
        .magnitude(freq_mag),
        .avg_log2(freq_avg_log2[r]),
        .clear_thr(freq_valid_thr[r]),
        .set_thr(freq_invalid_thr[r]),
        .flag(ref_freq_error_flag[r])
      );
    end
  endgenerate

  // PLL lock detectors
  genvar d;
  generate
    for (d = 0; d < N_DPLL; d++) begin : g_dpll
      logic locked_once, next_locked_once, next_lol;

      lmd_hyst_det #(.FLAG_RST(RST_LOCK_LOSS)) u_flock (
        .clk(clk),
        .rst_n(rst_n),
        .enable(1'b1),
        .sample(dpll_err_strobe[d]),
        .magnitude(dpll_freq_err[d]),
        .avg_log2(dpll_avg_log2[d]),
        .clear_thr(dpll_freq_lock_thr[d]),
        .set_thr(dpll_freq_unlock_thr[d]),
        .flag(freq_lock_loss_flag[d])
      );

      lmd_hyst_det #(.FLAG_RST(RST_LOCK_LOSS)) u_plock (
        .clk(clk),
        .rst_n(rst_n),
        .enable(1'b1),
        .sample(dpll_err_strobe[d]),
        .magnitude(dpll_phase_err[d]),
        .avg_log2(3'h0),
        .clear_thr(dpll_phase_lock_thr[d]),
        .set_thr(dpll_phase_unlock_thr[d]),
        .flag(phase_lock_loss_flag[d])
      );

      // Only the first lock after reset arms hitless 1-PPS switching; soft reset re-arms acquisition
      always_comb begin
        next_lol = freq_lock_loss_flag[d] | phase_lock_loss_flag[d];
        next_locked_once = dpll_soft_reset[d] ? 1'b0 : (locked_once | ~next_lol);
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          locked_once <= 1'b0;
          lock_loss_status[d] <= RST_LOCK_LOSS;
          hitless_pps_ok[d] <= 1'b0;
          sel_freq_error[d] <= RST_REF_FLAG;
          sel_window[d] <= RST_REF_FLAG;
          sel_phase_valid[d] <= RST_REF_FLAG;
        end else begin
          locked_once <= next_locked_once;
          lock_loss_status[d] <= next_lol;
          hitless_pps_ok[d] <= next_locked_once & ~zero_delay_sync[d];
          sel_freq_error[d] <= ref_freq_error_flag[dpll_sel_ref[d]];
          sel_window[d] <= ref_window_flag[dpll_sel_ref[d]];
          sel_phase_valid[d] <= ref_phase_valid_flag[dpll_sel_ref[d]];
        end
      end
    end

    for (d = 0; d < N_APLL; d++) begin : g_apll
      // Analog PLLs carry frequency lock only
      lmd_hyst_det #(.FLAG_RST(RST_LOCK_LOSS)) u_alock (
        .clk(clk),
        .rst_n(rst_n),
        .enable(1'b1),
        .sample(apll_err_strobe[d]),
        .magnitude(apll_freq_err[d]),
        .avg_log2(3'h0),
        .clear_thr(apll_lock_thr[d]),
        .set_thr(apll_unlock_thr[d]),
        .flag(apll_lock_loss_status[d])
      );
    end
  endgenerate

  // Status pins: any flag of any reference, selected or not
  logic [N_SRC-1:0] pin_src;
  logic [N_PIN-1:0] next_pin;

  always_comb begin
    pin_src = '0;
    pin_src[SRC_OSC] = osc_freq_loss_flag;
    pin_src[SRC_REF_FREQ +: N_REF] = ref_freq_error_flag;
    pin_src[SRC_REF_WIN +: N_REF] = ref_window_flag;
    pin_src[SRC_REF_PV +: N_REF] = ref_phase_valid_flag;
    pin_src[SRC_DPLL_LOL +: N_DPLL] = lock_loss_status;
    pin_src[SRC_APLL_LOL +: N_APLL] = apll_lock_loss_status;
    for (int p = 0; p < N_PIN; p++)
      next_pin[p] = pin_src[status_pin_sel[p]];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      status_pin <= '0;
    else
      status_pin <= next_pin;
  end
endmodule : lmd_ref_monitor

// file: verif/lmd_ref_monitor_checker.sv
/*
  Port-level assertions for lmd_ref_monitor, attached by the bind at the foot.
  Assumes the top's own clk and rstn; internal reset trails rstn by two edges.
*/
`timescale 1ns/1ps
module lmd_ref_monitor_checker import lmd_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic osc_detect_bypass,
  input wire logic [N_REF-1:0] late_en,
  input wire logic [N_REF-1:0] freq_mon_en,
  input wire logic [N_DPLL-1:0] dpll_sel_ref,
  input wire logic [N_DPLL-1:0] zero_delay_sync,
  input wire logic [N_PIN-1:0][SEL_W-1:0] status_pin_sel,
  input wire logic osc_freq_loss_flag,
  input wire logic osc_valid,
  input wire logic [N_REF-1:0] ref_freq_error_flag,
  input wire logic [N_REF-1:0] ref_window_flag,
  input wire logic [N_REF-1:0] ref_qualified,
  input wire logic [N_REF-1:0] ref_phase_valid_flag,
  input wire logic [N_DPLL-1:0] sel_freq_error,
  input wire logic [N_DPLL-1:0] sel_phase_valid,
  input wire logic [N_DPLL-1:0] sel_window,
  input wire logic [N_DPLL-1:0] freq_lock_loss_flag,
  input wire logic [N_DPLL-1:0] phase_lock_loss_flag,
  input wire logic [N_DPLL-1:0] lock_loss_status,
  input wire logic [N_DPLL-1:0] hitless_pps_ok,
  input wire logic [N_PIN-1:0] status_pin
);
  logic [1:0] age;
  logic [1:0] next_age;
  // Checks wait until the internal reset copy has surely let go
  assign next_age = (age == 2'h3) ? age : age + 2'h1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) age <= 2'h0;
    else age <= next_age;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (age != 2'h3);
  sequence s_off2(e);
    !e [*2];
  endsequence
  a_lock_or: assert property (lock_loss_status[0] ==
      $past(freq_lock_loss_flag[0] | phase_lock_loss_flag[0]))
    else $error("lock status is not the or of both losses");
  a_bypass_valid: assert property (osc_detect_bypass |=> osc_valid)
    else $error("bypass did not force oscillator valid");
  a_osc_band: assert property (s_off2(osc_detect_bypass) |-> osc_valid == !osc_freq_loss_flag)
    else $error("oscillator valid disagrees with loss flag");
  a_flag_dequal: assert property (ref_window_flag[0] |-> ##[1:2] !ref_qualified[0])
    else $error("flagged reference stayed qualified");
  a_late_quiet: assert property (s_off2(late_en[0]) |-> !ref_window_flag[0])
    else $error("disabled window monitor raised its flag");
  a_freq_quiet: assert property (s_off2(freq_mon_en[1]) |-> !ref_freq_error_flag[1])
    else $error("disabled frequency monitor raised its flag");
  a_zero_delay_off: assert property (zero_delay_sync[0] [*2] |-> !hitless_pps_ok[0])
    else $error("hitless allowed with zero delay sync");
  a_hitless_cause: assert property (hitless_pps_ok[0] |-> !$past(zero_delay_sync[0]))
    else $error("hitless raised while zero delay sync was on");
  a_sel_follow: assert property ($stable(dpll_sel_ref[0]) |->
      sel_window[0] == $past(dpll_sel_ref[0] ? ref_window_flag[1] : ref_window_flag[0]))
    else $error("selected window bit does not follow its reference");
  a_sel_freq: assert property (sel_freq_error[1] ==
      $past(dpll_sel_ref[1] ? ref_freq_error_flag[1] : ref_freq_error_flag[0]))
    else $error("selected frequency bit does not follow its reference");
  a_sel_phase: assert property (sel_phase_valid[1] ==
      $past(dpll_sel_ref[1] ? ref_phase_valid_flag[1] : ref_phase_valid_flag[0]))
    else $error("selected phase valid bit does not follow its reference");
  a_pin_window: assert property (status_pin_sel[0] == SRC_REF_WIN && $stable(status_pin_sel[0]) |->
      status_pin[0] == $past(ref_window_flag[0]))
    else $error("status pin does not show the window flag");
endmodule : lmd_ref_monitor_checker

bind lmd_ref_monitor lmd_ref_monitor_checker i_lmd_ref_monitor_checker (.clk, .rstn, .osc_detect_bypass,
  .late_en, .freq_mon_en, .dpll_sel_ref, .zero_delay_sync, .status_pin_sel, .osc_freq_loss_flag, .osc_valid,
  .ref_freq_error_flag, .ref_window_flag, .ref_qualified, .ref_phase_valid_flag, .sel_freq_error,
  .sel_phase_valid, .sel_window, .freq_lock_loss_flag,
  .phase_lock_loss_flag, .lock_loss_status, .hitless_pps_ok, .status_pin);

// file: verif/lmd_pulse_src.sv
/*
  Pulse source standing in for a reference clock or the divided oscillator.
  Assumes the bench changes period only between pulses; period zero means a gap.
*/
`timescale 1ns/1ps
module lmd_pulse_src import lmd_pkg::*; (
  input wire logic clk,
  input wire logic [CNT_W-1:0] period,
  output logic pulse
);
  logic [CNT_W-1:0] cnt = '0;
  initial pulse = 1'b0;
  // Period zero holds the line low, a missing pulse as seen by the monitors
  always @(posedge clk) begin
    if (period == '0) begin
      pulse <= 1'b0;
      cnt <= '0;
    end else if (cnt + 24'h1 >= period) begin
      pulse <= 1'b1;
      cnt <= '0;
    end else begin
      pulse <= 1'b0;
      cnt <= cnt + 24'h1;
    end
  end
endmodule : lmd_pulse_src

// file: verif/test_lmd_ref_monitor.sv
/*
  Self-checking bench for lmd_ref_monitor: pulse sources, lock strobes, queued checks.
  Assumes lmd_pkg, the pulse source and the checker bind are compiled first.
*/
`timescale 1ns/1ps
module test_lmd_ref_monitor import lmd_pkg::*; ;
  typedef struct {int k; logic e;} lmd_note_t;
  lmd_note_t q[$];
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic osc_div_tick, osc_detect_bypass;
  logic [N_REF-1:0] ref_in, freq_mon_en, late_en, early_en, phase_valid_en, valid_timer_en;
  logic [N_REF-1:0][CNT_W-1:0] nominal_period, late_threshold, early_threshold, jitter_window_threshold;
  logic [N_REF-1:0][CNT_W-1:0] freq_valid_thr, freq_invalid_thr, valid_timer;
  logic [N_REF-1:0][AVG_W-1:0] freq_avg_log2;
  logic [N_DPLL-1:0] dpll_sel_ref, zero_delay_sync, dpll_soft_reset, dpll_err_strobe;
  logic [N_DPLL-1:0][CNT_W-1:0] dpll_freq_err, dpll_phase_err, dpll_freq_lock_thr, dpll_freq_unlock_thr;
  logic [N_DPLL-1:0][CNT_W-1:0] dpll_phase_lock_thr, dpll_phase_unlock_thr;
  logic [N_DPLL-1:0][AVG_W-1:0] dpll_avg_log2;
  logic [N_APLL-1:0] apll_err_strobe;
  logic [N_APLL-1:0][CNT_W-1:0] apll_freq_err, apll_lock_thr, apll_unlock_thr;
  logic [N_PIN-1:0][SEL_W-1:0] status_pin_sel;
  logic osc_freq_loss_flag, osc_valid;
  logic [N_REF-1:0] ref_freq_error_flag, ref_window_flag, ref_phase_valid_flag, ref_qualified;
  logic [N_DPLL-1:0] sel_freq_error, sel_window, sel_phase_valid, freq_lock_loss_flag;
  logic [N_DPLL-1:0] phase_lock_loss_flag, lock_loss_status, hitless_pps_ok;
  logic [N_APLL-1:0] apll_lock_loss_status;
  logic [N_PIN-1:0] status_pin;
  logic [CNT_W-1:0] per0, per1, tick_per;
  logic [CNT_W-1:0] ot[4] = '{24'h8, 24'h14, 24'hFA, 24'h14};
  logic ol[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [CNT_W-1:0] rp[5] = '{24'h64, 24'h0, 24'h50, 24'h64, 24'h0};
  logic re[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic rw[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic rq[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [CNT_W-1:0] fp[5] = '{24'h64, 24'h68, 24'h6B, 24'h68, 24'h65};
  logic fq[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [CNT_W-1:0] df[5] = '{24'h0, 24'h96, 24'h12C, 24'h0, 24'h0};
  logic [CNT_W-1:0] dp[5] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h12C};
  logic ef[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic ep[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  int seed = 4150;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  wire [13:0] ob = {status_pin[1], hitless_pps_ok[0], apll_lock_loss_status[0], lock_loss_status[0],
    phase_lock_loss_flag[0], freq_lock_loss_flag[0], ref_phase_valid_flag[1], ref_freq_error_flag[1],
    status_pin[0], sel_window[0], ref_qualified[0], ref_window_flag[0], osc_valid, osc_freq_loss_flag};

  lmd_ref_monitor i_lmd_ref_monitor (.*);
  lmd_pulse_src i_lmd_pulse_src [2:0] (.clk(clk), .period({tick_per, per1, per0}), .pulse({osc_div_tick, ref_in}));

  initial forever #5 clk = ~clk;

  task automatic check(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic note(input int k, input logic e);
    q.push_back('{k, e});
  endtask : note
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic strobe(input logic [CNT_W-1:0] fe, input logic [CNT_W-1:0] pe);
    repeat (12) begin
      dpll_freq_err[0] = fe + 24'($unsigned($random(seed)) % 32'h14);
      dpll_phase_err[0] = pe + 24'($unsigned($random(seed)) % 32'h14);
      apll_freq_err[0] = dpll_freq_err[0];
      dpll_err_strobe[0] = 1'b1;
      apll_err_strobe[0] = 1'b1;
      cycles(1);
      dpll_err_strobe[0] = 1'b0;
      apll_err_strobe[0] = 1'b0;
      cycles(3);
    end
  endtask : strobe

  // Outputs are compared in the order the driver expected them
  initial begin : watch
    lmd_note_t n;
    forever begin
      wait (q.size() != 0);
      n = q.pop_front();
      check(ob[n.k], n.e);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    osc_detect_bypass = 1'b0;
    {dpll_sel_ref, zero_delay_sync, dpll_soft_reset, dpll_err_strobe, apll_err_strobe} = '0;
    {dpll_freq_err, dpll_phase_err, apll_freq_err} = '0;
    // Second DPLL watches the frequency and phase-valid reference so its selected bits move
    dpll_sel_ref[1] = 1'b1;
    nominal_period = {2{24'h64}};
    late_threshold = {2{24'hA}};
    early_threshold = {2{24'hA}};
    jitter_window_threshold = {2{24'hA}};
    freq_avg_log2 = {2{3'h1}};
    freq_valid_thr = {2{24'h2}};
    freq_invalid_thr = {2{24'h5}};
    valid_timer = {2{24'h32}};
    valid_timer_en = 2'h1;
    late_en = 2'h1;
    early_en = 2'h1;
    freq_mon_en = 2'h2;
    phase_valid_en = 2'h0;
    dpll_avg_log2 = {3{3'h2}};
    {dpll_freq_lock_thr, dpll_phase_lock_thr, apll_lock_thr} = {8{24'h64}};
    {dpll_freq_unlock_thr, dpll_phase_unlock_thr, apll_unlock_thr} = {8{24'hC8}};
    status_pin_sel = {4'(SRC_DPLL_LOL), 4'(SRC_REF_WIN)};
    {per0, per1, tick_per} = {24'h64, 24'h64, 24'h14};
    cycles(2);
    rstn = 1'b1;
    cycles(4);
    foreach (ot[i]) begin
      tick_per = ot[i];
      cycles(2100);
      note(0, ol[i]);
      note(1, !ol[i]);
    end
    tick_per = 24'h0;
    osc_detect_bypass = 1'b1;
    cycles(2100);
    note(0, 1'b1);
    note(1, 1'b1);
    osc_detect_bypass = 1'b0;
    tick_per = 24'h14;
    foreach (rp[i]) begin
      per0 = (rp[i] == 24'h64) ? 24'h61 + 24'($unsigned($random(seed)) % 32'h7) : rp[i];
      late_en[0] = re[i];
      early_en[0] = re[i];
      cycles(800);
      note(2, rw[i]);
      note(3, rq[i]);
      note(4, rw[i]);
      note(5, rw[i]);
    end
    foreach (fp[i]) begin
      per1 = fp[i];
      cycles(800);
      note(6, fq[i]);
    end
    freq_mon_en[1] = 1'b0;
    phase_valid_en[1] = 1'b1;
    per1 = 24'h64;
    cycles(400);
    note(7, 1'b0);
    per1 = 24'h0;
    cycles(400);
    note(7, 1'b1);
    note(6, 1'b0);
    foreach (df[i]) begin
      strobe(df[i], dp[i]);
      cycles(3);
      note(8, ef[i]);
      note(9, ep[i]);
      note(10, ef[i] | ep[i]);
      note(11, ef[i]);
      note(13, ef[i] | ep[i]);
      note(12, 1'b1);
    end
    zero_delay_sync[0] = 1'b1;
    cycles(3);
    note(12, 1'b0);
    zero_delay_sync[0] = 1'b0;
    dpll_soft_reset[0] = 1'b1;
    cycles(1);
    dpll_soft_reset[0] = 1'b0;
    cycles(5);
    note(12, 1'b0);
    wait (q.size() == 0);
    cycles(2);
    close_out();
  end
endmodule : test_lmd_ref_monitor
